//--- hdl/smed_consts.svh
// Constants, register map and field positions for the receive message end detector
`ifndef SMED_CONSTS_SVH
`define SMED_CONSTS_SVH

// Register byte addresses
`define SMED_A_CTRL     12'h000
`define SMED_A_MSGTO    12'h004
`define SMED_A_RSPTO    12'h008
`define SMED_A_GAP      12'h00C
`define SMED_A_MAXLEN   12'h010
`define SMED_A_LENCFG   12'h014
`define SMED_A_ENDCHR   12'h018
`define SMED_A_SEQVAL   12'h01C
`define SMED_A_SEQCHK   12'h020
`define SMED_A_BAUD     12'h024
`define SMED_A_STAT     12'h028
`define SMED_A_MASK     12'h02C
`define SMED_A_CAUSE    12'h030
`define SMED_A_COUNT    12'h034

// Control bits
`define SMED_C_MSGTO    0
`define SMED_C_RSPTO    1
`define SMED_C_GAP      2
`define SMED_C_MAXLEN   3
`define SMED_C_LENMSG   4
`define SMED_C_ENDCHR   5
`define SMED_C_SEQ      6
`define SMED_C_LITTLE   7

// Status bits
`define SMED_S_END      0
`define SMED_S_RSPTO    1

// Reset values
`define SMED_RST_CTRL   8'h00
`define SMED_RST_TO     16'h00C8
`define SMED_RST_GAP    16'h000C
`define SMED_RST_MAXLEN 11'h000
`define SMED_RST_BAUD   16'h01B2
`define SMED_MAXLEN_LIM 11'h400

// Timing: 1 ms at the clock rate
`define SMED_CLK_HZ     50000000
`define SMED_MS_PER_S   1000
`define SMED_MS_CYC     (`SMED_CLK_HZ / `SMED_MS_PER_S)
`define SMED_GAP_CAP_S  8
`define SMED_SEQ_N      5

`endif

//--- hdl/smed_pkg.sv
// Types shared by the receive message end detector
package smed_pkg;
  typedef enum logic [2:0] {
    SMED_CAUSE_NONE   = 3'b000,
    SMED_CAUSE_MSGTO  = 3'b001,
    SMED_CAUSE_GAP    = 3'b010,
    SMED_CAUSE_MAXLEN = 3'b011,
    SMED_CAUSE_LENMSG = 3'b100,
    SMED_CAUSE_ENDCHR = 3'b101,
    SMED_CAUSE_SEQ    = 3'b110,
    SMED_CAUSE_RSPTO  = 3'b111
  } smed_cause_t;

  typedef enum logic [1:0] {
    SMED_ST_IDLE = 2'b00,
    SMED_ST_WAIT = 2'b01,
    SMED_ST_RECV = 2'b10
  } smed_state_t;

  typedef struct packed {
    logic       valid;
    logic [7:0] data;
  } smed_char_t;

  typedef struct packed {
    logic        done;
    smed_cause_t cause;
    logic [10:0] count;
  } smed_end_t;
endpackage : smed_pkg

//--- hdl/smed_seq_match.sv
// Masked end-sequence matcher over the last five received characters
`timescale 1ns/1ps
`default_nettype none
`include "smed_consts.svh"

module smed_seq_match #(
  parameter int N = `SMED_SEQ_N
) (
  // Clock and reset
  input  wire logic               pclk,
  input  wire logic               presetn,
  // Character stream
  input  wire smed_pkg::smed_char_t rx,
  input  wire logic               clear,
  // Pattern
  input  wire logic [8*N-1:0]     pat_val,
  input  wire logic [N-1:0]       pat_chk,
  // Result
  output logic                    hit
);
  import smed_pkg::*;

  logic [8*N-1:0] hist_r;
  logic [8*N-1:0] hist_nxt;
  logic [3:0]     fill_r;
  logic [3:0]     fill_nxt;

  // Slot 0 is the oldest pattern position; history slot N-1 is the newest char
  always_comb
  begin
    hist_nxt = hist_r;
    fill_nxt = fill_r;
    if (clear)
    begin
      fill_nxt = 4'h0;
    end
    else if (rx.valid)
    begin
      hist_nxt = {rx.data, hist_r[8*N-1:8]};
      if (fill_r < 4'(N))
        fill_nxt = fill_r + 4'h1;
    end
  end

  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      hist_r <= '0;
      fill_r <= 4'h0;
    end
    else
    begin
      hist_r <= hist_nxt;
      fill_r <= fill_nxt;
    end
  end

  // Leading ignored positions are dropped by requiring only chars from the
  // first checked slot on; trailing ignored slots still need a character
  always_comb
  begin
    logic ok;
    int   first;
    ok    = 1'b0;
    first = N;
    for (int i = N - 1; i >= 0; i--)
      if (pat_chk[i])
        first = i;
    if (first < N && fill_r >= 4'(N - first))
    begin
      ok = 1'b1;
      for (int i = 0; i < N; i++)
        if (pat_chk[i] && hist_r[8*i +: 8] != pat_val[8*i +: 8])
          ok = 1'b0;
    end
    hit = ok;
  end
endmodule : smed_seq_match
`default_nettype wire

//--- hdl/smed_end_detect.sv
// Receive message end detector with APB registers and interrupt
`timescale 1ns/1ps
`default_nettype none
`include "smed_consts.svh"

module smed_end_detect #(
  parameter int MS_CYC = `SMED_MS_CYC
) (
  // APB slave
  input  wire logic        pclk,
  input  wire logic        presetn,
  input  wire logic        psel,
  input  wire logic        penable,
  input  wire logic        pwrite,
  input  wire logic [11:0] paddr,
  input  wire logic [31:0] pwdata,
  output logic             pready,
  output logic             pslverr,
  output logic [31:0]      prdata,
  // Receiver side
  input  wire smed_pkg::smed_char_t rx,
  input  wire logic        msg_start,
  input  wire logic        tx_done,
  // Results
  output smed_pkg::smed_end_t msg_end,
  output logic             irq
);
  import smed_pkg::*;

  // Registers
  logic [7:0]  ctrl_r;
  logic [15:0] msgto_r;
  logic [15:0] rspto_r;
  logic [15:0] gap_r;
  logic [10:0] maxlen_r;
  logic [15:0] lenpos_r;
  logic [2:0]  lensz_r;
  logic [7:0]  lenm_r;
  logic [7:0]  endchr_r;
  logic [39:0] seqval_r;
  logic [4:0]  seqchk_r;
  logic [15:0] baud_r;
  logic [1:0]  stat_r;
  logic [1:0]  mask_r;

  // Receive state
  smed_state_t st_r, st_nxt;
  logic [10:0] cnt_r, cnt_nxt;
  logic [31:0] len_r, len_nxt;
  logic [15:0] ms_r, ms_nxt;
  logic [31:0] msdiv_r, msdiv_nxt;
  logic [15:0] bdiv_r, bdiv_nxt;
  logic [15:0] bits_r, bits_nxt;
  logic [31:0] gcap_r, gcap_nxt;
  smed_end_t   end_r, end_nxt;

  logic        seq_hit;
  smed_char_t  rx_in;
  logic        apb_wr;
  logic        apb_rd_ok;
  logic [31:0] rd_data;

  function automatic logic [31:0] len_total(input logic [31:0] len, input logic [15:0] pos,
                                            input logic [2:0] sz, input logic [7:0] m);
    len_total = len + 32'(pos) + 32'(sz) - 32'h0000_0001 + 32'(m);
  endfunction : len_total

  smed_seq_match #(
    .N (`SMED_SEQ_N)
  ) u_seq (
    .pclk    (pclk),
    .presetn (presetn),
    .rx      (rx_in),
    .clear   (end_nxt.done),
    .pat_val (seqval_r),
    .pat_chk (seqchk_r),
    .hit     (seq_hit)
  );
  // Chars outside a message stay out of the history, or a stale byte could complete a pattern
  assign rx_in = {rx.valid && st_r == SMED_ST_RECV, rx.data};

  // APB: zero wait states, unmapped addresses error
  assign pready = 1'b1;
  assign apb_wr = psel && penable && pwrite;

  always_comb
  begin
    apb_rd_ok = 1'b1;
    rd_data   = 32'h0000_0000;
    case (paddr)
      `SMED_A_CTRL:   rd_data = 32'(ctrl_r);
      `SMED_A_MSGTO:  rd_data = 32'(msgto_r);
      `SMED_A_RSPTO:  rd_data = 32'(rspto_r);
      `SMED_A_GAP:    rd_data = 32'(gap_r);
      `SMED_A_MAXLEN: rd_data = 32'(maxlen_r);
      `SMED_A_LENCFG: rd_data = {lenm_r, 5'h00, lensz_r, lenpos_r};
      `SMED_A_ENDCHR: rd_data = 32'(endchr_r);
      `SMED_A_SEQVAL: rd_data = seqval_r[31:0];
      `SMED_A_SEQCHK: rd_data = {19'h0_0000, seqchk_r, seqval_r[39:32]};
      `SMED_A_BAUD:   rd_data = 32'(baud_r);
      `SMED_A_STAT:   rd_data = 32'(stat_r);
      `SMED_A_MASK:   rd_data = 32'(mask_r);
      `SMED_A_CAUSE:  rd_data = 32'(end_r.cause);
      `SMED_A_COUNT:  rd_data = 32'(end_r.count);
      default:        apb_rd_ok = 1'b0;
    endcase
  end

  assign pslverr = psel && penable && !apb_rd_ok;

  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
      prdata <= 32'h0000_0000;
    else if (psel && !penable && !pwrite)
      prdata <= rd_data;
  end

  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      ctrl_r   <= `SMED_RST_CTRL;
      msgto_r  <= `SMED_RST_TO;
      rspto_r  <= `SMED_RST_TO;
      gap_r    <= `SMED_RST_GAP;
      maxlen_r <= `SMED_RST_MAXLEN;
      lenpos_r <= 16'h0001;
      lensz_r  <= 3'h1;
      lenm_r   <= 8'h00;
      endchr_r <= 8'h00;
      seqval_r <= '0;
      seqchk_r <= 5'h00;
      baud_r   <= `SMED_RST_BAUD;
      mask_r   <= 2'h0;
    end
    else if (apb_wr)
    begin
      case (paddr)
        `SMED_A_CTRL:   ctrl_r <= pwdata[7:0];
        `SMED_A_MSGTO:  msgto_r <= pwdata[15:0];
        `SMED_A_RSPTO:  rspto_r <= pwdata[15:0];
        `SMED_A_GAP:    gap_r <= pwdata[15:0];
        `SMED_A_MAXLEN: maxlen_r <= (pwdata[10:0] > `SMED_MAXLEN_LIM) ? `SMED_MAXLEN_LIM : pwdata[10:0];
        `SMED_A_LENCFG:
        begin
          lenpos_r <= pwdata[15:0];
          lensz_r  <= (pwdata[18:16] == 3'h2 || pwdata[18:16] == 3'h4) ? pwdata[18:16] : 3'h1;
          lenm_r   <= pwdata[31:24];
        end
        `SMED_A_ENDCHR: endchr_r <= pwdata[7:0];
        `SMED_A_SEQVAL: seqval_r[31:0] <= pwdata;
        `SMED_A_SEQCHK:
        begin
          seqval_r[39:32] <= pwdata[7:0];
          seqchk_r        <= pwdata[12:8];
        end
        `SMED_A_BAUD:   baud_r <= (pwdata[15:0] == 16'h0000) ? 16'h0001 : pwdata[15:0];
        `SMED_A_MASK:   mask_r <= pwdata[1:0];
        default:        ;
      endcase
    end
  end

  // Sticky status; a new event wins over a write-one clear
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
      stat_r <= 2'h0;
    else
    begin
      for (int i = 0; i < 2; i++)
      begin
        if (end_nxt.done && (i == `SMED_S_END || end_nxt.cause == SMED_CAUSE_RSPTO))
          stat_r[i] <= 1'b1;
        else if (apb_wr && paddr == `SMED_A_STAT && pwdata[i])
          stat_r[i] <= 1'b0;
      end
    end
  end

  assign irq = |(stat_r & mask_r);

  // Receive side
  always_comb
  begin
    logic        ch;
    logic        ms_tick;
    logic        bit_tick;
    logic [10:0] cnt1;
    logic [31:0] tot;
    ch        = rx.valid && st_r == SMED_ST_RECV;
    st_nxt    = st_r;
    cnt_nxt   = cnt_r;
    len_nxt   = len_r;
    end_nxt   = end_r;
    end_nxt.done = 1'b0;
    cnt1      = cnt_r + 11'h001;
    tot       = len_total(len_r, lenpos_r, lensz_r, lenm_r);
    // Millisecond base
    ms_tick   = (msdiv_r == 32'(MS_CYC - 1));
    msdiv_nxt = ms_tick ? 32'h0000_0000 : msdiv_r + 32'h0000_0001;
    ms_nxt    = ms_r;
    if (ms_tick && ms_r != 16'hFFFF)
      ms_nxt = ms_r + 16'h0001;
    // Bit time base follows the baud divisor
    bit_tick  = (bdiv_r >= baud_r - 16'h0001);
    bdiv_nxt  = bit_tick ? 16'h0000 : bdiv_r + 16'h0001;
    bits_nxt  = bits_r;
    if (bit_tick && bits_r != 16'hFFFF)
      bits_nxt = bits_r + 16'h0001;
    gcap_nxt  = (gcap_r == 32'hFFFF_FFFF) ? gcap_r : gcap_r + 32'h0000_0001;

    case (st_r)
      SMED_ST_IDLE:
      begin
        if (msg_start)
        begin
          st_nxt = SMED_ST_RECV;
          ms_nxt = 16'h0000;
          msdiv_nxt = 32'h0000_0000;
        end
        else if (tx_done && ctrl_r[`SMED_C_RSPTO])
        begin
          st_nxt = SMED_ST_WAIT;
          ms_nxt = 16'h0000;
          msdiv_nxt = 32'h0000_0000;
        end
      end
      SMED_ST_WAIT:
      begin
        if (msg_start)
        begin
          st_nxt = SMED_ST_RECV;
          ms_nxt = 16'h0000;
          msdiv_nxt = 32'h0000_0000;
        end
        else if (ms_r >= rspto_r)
        begin
          end_nxt.done  = 1'b1;
          end_nxt.cause = SMED_CAUSE_RSPTO;
          end_nxt.count = 11'h000;
        end
      end
      SMED_ST_RECV:
      begin
        if (ch)
        begin
          cnt_nxt  = cnt1;
          bits_nxt = 16'h0000;
          bdiv_nxt = 16'h0000;
          gcap_nxt = 32'h0000_0000;
          // Length field capture, big-endian unless configured little
          if (cnt1 >= 11'(lenpos_r) && cnt1 < 11'(lenpos_r) + 11'(lensz_r))
          begin
            if (ctrl_r[`SMED_C_LITTLE])
              len_nxt = len_r | (32'(rx.data) << (8 * (cnt1 - 11'(lenpos_r))));
            else
              len_nxt = {len_r[23:0], rx.data};
          end
        end
        // Priority only picks the reported cause; all are evaluated together
        if (ctrl_r[`SMED_C_MSGTO] && ms_r >= msgto_r)
        begin
          end_nxt.done  = 1'b1;
          end_nxt.cause = SMED_CAUSE_MSGTO;
        end
        else if (ctrl_r[`SMED_C_GAP] && cnt_r != 11'h000 &&
                 (bits_r > gap_r || gcap_r >= 32'(`SMED_CLK_HZ) * `SMED_GAP_CAP_S))
        begin
          end_nxt.done  = 1'b1;
          end_nxt.cause = SMED_CAUSE_GAP;
        end
        else if (ch && ctrl_r[`SMED_C_MAXLEN] && cnt1 >= maxlen_r)
        begin
          end_nxt.done  = 1'b1;
          end_nxt.cause = SMED_CAUSE_MAXLEN;
        end
        else if (ch && ctrl_r[`SMED_C_LENMSG] && cnt_r >= 11'(lenpos_r) + 11'(lensz_r) - 11'h001 &&
                 32'(cnt1) >= tot)
        begin
          end_nxt.done  = 1'b1;
          end_nxt.cause = SMED_CAUSE_LENMSG;
        end
        else if (ch && ctrl_r[`SMED_C_ENDCHR] && rx.data == endchr_r)
        begin
          end_nxt.done  = 1'b1;
          end_nxt.cause = SMED_CAUSE_ENDCHR;
        end
        else if (ctrl_r[`SMED_C_SEQ] && seq_hit && cnt_r != 11'h000)
        begin
          end_nxt.done  = 1'b1;
          end_nxt.cause = SMED_CAUSE_SEQ;
        end
        if (end_nxt.done)
          end_nxt.count = cnt_nxt;
      end
      default: st_nxt = SMED_ST_IDLE;
    endcase

    if (end_nxt.done)
    begin
      st_nxt  = SMED_ST_IDLE;
      cnt_nxt = 11'h000;
      len_nxt = 32'h0000_0000;
    end
  end

  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      st_r    <= SMED_ST_IDLE;
      cnt_r   <= 11'h000;
      len_r   <= 32'h0000_0000;
      ms_r    <= 16'h0000;
      msdiv_r <= 32'h0000_0000;
      bdiv_r  <= 16'h0000;
      bits_r  <= 16'h0000;
      gcap_r  <= 32'h0000_0000;
      end_r   <= '0;
    end
    else
    begin
      st_r    <= st_nxt;
      cnt_r   <= cnt_nxt;
      len_r   <= len_nxt;
      ms_r    <= ms_nxt;
      msdiv_r <= msdiv_nxt;
      bdiv_r  <= bdiv_nxt;
      bits_r  <= bits_nxt;
      gcap_r  <= gcap_nxt;
      end_r   <= end_nxt;
    end
  end

  assign msg_end = end_r;
endmodule : smed_end_detect
`default_nettype wire

//--- tb/smed_end_detect_assertions.sv
// Port-level properties of the receive message end detector
`timescale 1ns/1ps
`default_nettype none
`include "smed_consts.svh"

module smed_chk #(
  parameter int MS_CYC = 50000
) (
  // APB slave
  input wire logic                 pclk,
  input wire logic                 presetn,
  input wire logic                 psel,
  input wire logic                 penable,
  input wire logic                 pwrite,
  input wire logic [11:0]          paddr,
  input wire logic [31:0]          pwdata,
  input wire logic                 pready,
  input wire logic                 pslverr,
  input wire logic [31:0]          prdata,
  // Receiver and results
  input wire smed_pkg::smed_char_t rx,
  input wire logic                 msg_start,
  input wire logic                 tx_done,
  input wire smed_pkg::smed_end_t  msg_end,
  input wire logic                 irq
);
  import smed_pkg::*;
  logic        wr;
  logic        recv_r;
  logic [7:0]  ctrl_r;
  logic [7:0]  mask_r;
  logic [7:0]  echr_r;
  logic [10:0] max_r;
  assign wr = psel && penable && pwrite;
  // Shadow copies of the settings that the properties depend on
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      ctrl_r <= 8'h00;
      mask_r <= 8'h00;
      echr_r <= 8'h00;
      max_r  <= 11'h000;
      recv_r <= 1'b0;
    end
    else
    begin
      if (wr && paddr == `SMED_A_CTRL)
        ctrl_r <= pwdata[7:0];
      if (wr && paddr == `SMED_A_MASK)
        mask_r <= pwdata[7:0];
      if (wr && paddr == `SMED_A_ENDCHR)
        echr_r <= pwdata[7:0];
      if (wr && paddr == `SMED_A_MAXLEN)
        max_r <= (pwdata[10:0] > `SMED_MAXLEN_LIM) ? `SMED_MAXLEN_LIM : pwdata[10:0];
      recv_r <= msg_start || (recv_r && !msg_end.done);
    end
  end
  default clocking dc @(posedge pclk);
  endclocking
  default disable iff (!presetn);
  ready_high_a: assert property (pready)
    else $error("pready low");
  err_map_a: assert property (psel && penable && paddr[1:0] == 2'b00 |-> pslverr == (paddr > `SMED_A_COUNT))
    else $error("pslverr does not follow the map");
  err_rdata_a: assert property (psel && penable && !pwrite && pslverr |-> prdata == 32'h0000_0000)
    else $error("refused read returned data");
  end_pulse_a: assert property (msg_end.done |=> !msg_end.done)
    else $error("end pulse longer than one cycle");
  cause_set_a: assert property (msg_end.done |-> msg_end.cause != SMED_CAUSE_NONE)
    else $error("end without a cause");
  result_hold_a: assert property (!msg_end.done |-> $stable(msg_end.cause) && $stable(msg_end.count))
    else $error("result changed without an end");
  irq_set_a: assert property (msg_end.done && mask_r[0] |-> irq)
    else $error("unmasked end without interrupt");
  irq_clear_a: assert property (wr && paddr == `SMED_A_STAT && pwdata[1:0] == 2'b11 ##1 !msg_end.done |-> !irq)
    else $error("interrupt survived its clear");
  endchr_hit_a: assert property (rx.valid && recv_r && !msg_end.done && ctrl_r[`SMED_C_ENDCHR]
    && rx.data == echr_r |=> msg_end.done)
    else $error("end character missed");
  maxlen_cnt_a: assert property (msg_end.done && msg_end.cause == SMED_CAUSE_MAXLEN && max_r != 11'h000
    |-> msg_end.count == max_r)
    else $error("length end at wrong count");
endmodule : smed_chk

bind smed_end_detect smed_chk #(.MS_CYC(MS_CYC)) i_smed_chk (
  .pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable), .pwrite(pwrite),
  .paddr(paddr), .pwdata(pwdata), .pready(pready), .pslverr(pslverr), .prdata(prdata),
  .rx(rx), .msg_start(msg_start), .tx_done(tx_done), .msg_end(msg_end), .irq(irq));
`default_nettype wire

//--- tb/smed_far_dev.sv
// Behavioural serial device feeding characters to the end detector
`timescale 1ns/1ps
`default_nettype none

module smed_far_dev (
  // Clock
  input  wire logic                pclk,
  // Character stream
  output var smed_pkg::smed_char_t rx,
  output var logic                 msg_start
);
  import smed_pkg::*;
  initial
  begin
    rx = '0;
    msg_start = 1'b0;
  end
  // Start criteria met; that character is not counted
  task automatic open_msg();
    @(posedge pclk);
    msg_start <= 1'b1;
    @(posedge pclk);
    msg_start <= 1'b0;
  endtask : open_msg
  // Idle data keeps toggling so a stale byte never looks valid
  task automatic send(input logic [7:0] d, input int idle);
    @(posedge pclk);
    rx <= '{valid: 1'b1, data: d};
    @(posedge pclk);
    rx <= '{valid: 1'b0, data: ~d};
    repeat (idle)
    begin
      @(posedge pclk);
      rx.data <= ~rx.data;
    end
  endtask : send
endmodule : smed_far_dev
`default_nettype wire

//--- tb/tb.sv
// Self-checking bench for the receive message end detector
`timescale 1ns/1ps
`default_nettype none
`include "smed_consts.svh"

module tb;
  import smed_pkg::*;
  logic        pclk, presetn, psel, penable, pwrite, tx_done;
  logic        pready, pslverr, irq, last_err, got_end, msg_start;
  logic [11:0] paddr;
  logic [31:0] pwdata, rdata, rdata_w;
  logic [7:0]  q[$];
  smed_char_t  rx;
  smed_end_t   msg_end, end_cap;
  int          err_total, total_checks, cyc, wait_n;

  smed_end_detect #(.MS_CYC(50)) i_smed_end_detect (.pclk(pclk), .presetn(presetn), .psel(psel),
    .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .pready(pready),
    .pslverr(pslverr), .prdata(rdata_w), .rx(rx), .msg_start(msg_start), .tx_done(tx_done),
    .msg_end(msg_end), .irq(irq));
  smed_far_dev i_smed_far_dev (.pclk(pclk), .rx(rx), .msg_start(msg_start));

  initial
  begin
    pclk = 1'b0;
    forever #10 pclk = ~pclk;
  end
  // The end pulse may come while a send is still running
  always @(posedge pclk)
  begin
    cyc <= cyc + 1;
    if (msg_end.done === 1'b1)
    begin
      got_end <= 1'b1;
      end_cap <= msg_end;
    end
    if (cyc == 20000)
    begin
      err_total++;
      report_and_stop();
    end
  end

  task automatic report_and_stop();
    $display("checks %0d mismatches %0d", total_checks, err_total);
    if (err_total == 0 && total_checks > 0)
      $display("Run complete: PASS");
    else
      $display("Run complete: FAIL");
    $finish;
  endtask : report_and_stop

  task automatic check(input logic [31:0] g, input logic [31:0] e, input string what);
    total_checks++;
    if (g !== e)
    begin
      err_total++;
      $display("BAD t=%0t %s got %h exp %h", $time, what, g, e);
    end
  endtask : check

  task automatic xfer(input logic [11:0] a, input logic w, input logic [31:0] d);
    @(posedge pclk);
    psel    <= 1'b1;
    penable <= 1'b0;
    paddr   <= a;
    pwrite  <= w;
    pwdata  <= d;
    @(posedge pclk);
    penable <= 1'b1;
    do
      @(posedge pclk);
    while (pready !== 1'b1);
    rdata    = rdata_w;
    last_err = pslverr;
    psel    <= 1'b0;
    penable <= 1'b0;
  endtask : xfer

  task automatic wr(input logic [11:0] a, input logic [31:0] d);
    xfer(a, 1'b1, d);
  endtask : wr

  task automatic rd(input logic [11:0] a, input logic [31:0] e, input string what);
    xfer(a, 1'b0, 32'h0000_0000);
    check(rdata, e, what);
  endtask : rd

  task automatic run_msg(input logic [31:0] ctrl, input int idle);
    wr(`SMED_A_CTRL, ctrl);
    i_smed_far_dev.open_msg();
    foreach (q[i])
      i_smed_far_dev.send(q[i], idle);
  endtask : run_msg

  // A count of all ones skips the count comparison
  task automatic wait_end(input smed_cause_t c, input logic [10:0] n, input string what);
    wait_n = 0;
    while (got_end !== 1'b1 && wait_n < 400)
    begin
      @(posedge pclk);
      #1;
      wait_n++;
    end
    check({31'b0, got_end}, 32'h0000_0001, what);
    check(32'(end_cap.cause), 32'(c), what);
    if (n !== 11'h7FF)
      check({21'b0, end_cap.count}, {21'b0, n}, what);
    got_end = 1'b0;
    $display("test %s done", what);
  endtask : wait_end

  initial
  begin
    {psel, penable, pwrite, tx_done, got_end, presetn} = 6'b000000;
    paddr = 12'h000;
    pwdata = 32'h0000_0000;
    {err_total, total_checks, cyc} = 0;
    repeat (5) @(posedge pclk);
    presetn <= 1'b1;
    rd(`SMED_A_CTRL, 32'h0000_0000, "ctrl reset");
    rd(`SMED_A_MSGTO, 32'h0000_00C8, "msg timeout reset");
    rd(`SMED_A_RSPTO, 32'h0000_00C8, "rsp timeout reset");
    rd(`SMED_A_GAP, 32'h0000_000C, "gap reset");
    rd(`SMED_A_MAXLEN, 32'h0000_0000, "maxlen reset");
    rd(12'h040, 32'h0000_0000, "unmapped");
    check({31'b0, last_err}, 32'h0000_0001, "slverr");
    $display("test registers done");
    wr(`SMED_A_MASK, 32'h0000_0001);
    wr(`SMED_A_ENDCHR, 32'h0000_0041);
    wr(`SMED_A_MAXLEN, 32'h0000_0003);
    q = '{8'h10, 8'h41};
    run_msg(32'h0000_0028, 0);
    wait_end(SMED_CAUSE_ENDCHR, 11'd2, "end char");
    check({31'b0, irq}, 32'h0000_0001, "irq set");
    rd(`SMED_A_STAT, 32'h0000_0001, "status");
    wr(`SMED_A_STAT, 32'h0000_0003);
    rd(`SMED_A_COUNT, 32'h0000_0002, "count reg");
    rd(`SMED_A_CAUSE, 32'h0000_0005, "cause reg");
    check({31'b0, irq}, 32'h0000_0000, "irq clear");
    q = '{8'h01, 8'h02, 8'h03, 8'h04};
    run_msg(32'h0000_0028, 0);
    wait_end(SMED_CAUSE_MAXLEN, 11'd3, "max length");
    wr(`SMED_A_LENCFG, 32'h0102_0001);
    q = '{8'h00, 8'h02, 8'hAA, 8'hBB, 8'hCC, 8'hDD};
    run_msg(32'h0000_0010, 0);
    wait_end(SMED_CAUSE_LENMSG, 11'd5, "length big endian");
    wr(`SMED_A_LENCFG, 32'h0004_0002);
    q = '{8'h55, 8'h01, 8'h00, 8'h00, 8'h00, 8'hAA, 8'hBB};
    run_msg(32'h0000_0090, 0);
    wait_end(SMED_CAUSE_LENMSG, 11'd6, "length little endian");
    wr(`SMED_A_SEQVAL, 32'h007A_7A00);
    wr(`SMED_A_SEQCHK, 32'h0000_0600);
    q = '{8'h7A, 8'h7A, 8'h11, 8'h22};
    run_msg(32'h0000_0040, 2);
    wait_end(SMED_CAUSE_SEQ, 11'd4, "sequence");
    wr(`SMED_A_BAUD, 32'h0000_0004);
    wr(`SMED_A_GAP, 32'h0000_0003);
    q = '{8'h01, 8'h02, 8'h03};
    run_msg(32'h0000_0004, 8);
    wait_end(SMED_CAUSE_GAP, 11'd3, "gap");
    check({31'b0, wait_n > 1 && wait_n < 13}, 32'h0000_0001, "gap time");
    wr(`SMED_A_MSGTO, 32'h0000_0002);
    q = {};
    run_msg(32'h0000_0001, 0);
    wait_end(SMED_CAUSE_MSGTO, 11'd0, "msg timeout");
    check({31'b0, wait_n > 94 && wait_n < 106}, 32'h0000_0001, "msg time");
    wr(`SMED_A_RSPTO, 32'h0000_0001);
    wr(`SMED_A_CTRL, 32'h0000_0022);
    @(posedge pclk);
    tx_done <= 1'b1;
    @(posedge pclk);
    tx_done <= 1'b0;
    wait_end(SMED_CAUSE_RSPTO, 11'h7FF, "rsp timeout");
    check({31'b0, wait_n > 44 && wait_n < 56}, 32'h0000_0001, "rsp time");
    rd(`SMED_A_STAT, 32'h0000_0003, "rsp status");
    rd(`SMED_A_CAUSE, 32'h0000_0007, "rsp cause reg");
    report_and_stop();
  end
endmodule : tb
`default_nettype wire
